// *** core/bcp_defs.vh ***
// Purpose: Shared offsets, field positions and codes for the bus com port data path.
// Assumes: APB byte addresses, 32-bit data.
// Notes: Flag byte codes are plain defaults; adjust to the link protocol in use.
`ifndef BCP_DEFS_VH
`define BCP_DEFS_VH
`define BCP_OFF_NONBLOCK 12'h020
`define BCP_OFF_STATUS_A 12'h02c
`define BCP_OFF_BLOCK 12'h030
`define BCP_OFF_STATUS_B 12'h03c
`define BCP_BIT_PEN 31
`define BCP_BIT_TX_LINK_FAULT 14
`define BCP_BIT_TX_OVERFLOW_FLAG 13
`define BCP_BIT_REMOTE_REBOOT_BLOCK 12
`define BCP_TXS_RESET 8'h01
`define BCP_NULL_BYTE 8'h00
`define BCP_LINK_FAULT_FLAG_BYTE_BYTE 8'ha0
`define BCP_REBOOT_BYTE 8'hab
`endif

// *** core/bcp_fifo.v ***
// Purpose: Small byte FIFO with registered read data.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Push into a full FIFO is dropped; the transmit caller checks space first, the receive caller does not.
`timescale 1ns/10ps
module bcp_fifo #(
  parameter AW = 4
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire push_i,
  input wire [7:0] wdata_i,
  input wire pop_i,
  output reg [7:0] rdata_o,
  output reg [AW:0] count_o
);
  reg [7:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  wire do_push = push_i && (count_o != (1 << AW));
  wire do_pop = pop_i && (count_o != 0);
  // Pointers, fill count and registered head of queue.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count_o <= {(AW+1){1'b0}};
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (do_push) begin
        mem[wp] <= wdata_i;
        wp <= wp + 1'b1;
      end
      if (do_pop) begin
        rdata_o <= mem[rp];
        rp <= rp + 1'b1;
      end
      count_o <= count_o + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule

// *** core/bcp_core.v ***
// Purpose: Transmit status and blocking/non-blocking data registers of a debug com port.
// Assumes: APB slave on clk_i; one APB access byte-packs up to four bytes.
// Notes: Transmit FIFO accepts one byte per cycle; receive bytes enter rx_push_i.
//   Link bytes leave at most one every other cycle through the link register.
//   Free space and the port enable lag their sources by a cycle or two.
`timescale 1ns/10ps
`include "bcp_defs.vh"
module bcp_core #(
  parameter TX_PRESENT = 1,
  parameter RX_PRESENT = 1,
  parameter TX_BYTE_WIDTH = 4,
  parameter TX_AW = 4,
  parameter RX_AW = 4
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire port_enable_input_i,
  input wire reboot_block_input_i,
  input wire link_up_i,
  output reg tx_valid_o,
  output reg [7:0] tx_data_o,
  input wire tx_ready_i,
  input wire rx_push_i,
  input wire [7:0] rx_data_i,
  output reg rx_link_fault_push_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PUSH = 2'h1;
  localparam ST_DONE = 2'h2;
  // Full FIFO depth at the width of the fill count, so no bits are lost.
  localparam [TX_AW:0] TX_DEPTH = {1'b1, {TX_AW{1'b0}}};
  // Synchronisers for the two configuration levels.
  reg pen_m;
  reg port_enabled;
  reg rrd_m;
  reg remote_reboot_block;
  reg tx_link_fault;
  reg tx_overflow_flag;
  // Free-space field is registered so that it can show its reset value.
  reg [7:0] tx_free_space;
  // High for the cycle after a transmit pop, while the FIFO head register loads.
  // This halves the link rate but keeps the link outputs straight from flops.
  reg tx_load;
  // Blocking write waiting in lane 0 for room.
  reg wr_stall;
  reg [1:0] state;
  reg [31:0] wbuf;
  reg [2:0] lane;
  reg blocking;
  reg [1:0] rd_pend;
  reg [31:0] rd_acc;
  wire [TX_AW:0] tx_cnt;
  wire [7:0] tx_head;
  wire [RX_AW:0] rx_cnt;
  wire [7:0] rx_head;
  reg tx_push;
  reg [7:0] tx_byte;
  reg tx_pop;
  reg rx_pop;
  reg drop_ev;
  reg ovf_ev;
  // Counts bytes to enqueue, skipping nulls and lanes past the width.
  function [2:0] needed;
    input [31:0] d;
    integer i;
    begin
      needed = 3'h0;
      for (i = 0; i < 4; i = i + 1) begin
        if (i < TX_BYTE_WIDTH && d[8*i +: 8] != `BCP_NULL_BYTE)
          needed = needed + 3'h1;
      end
    end
  endfunction
  // Clamps a count to the eight bits of the free-space field.
  function [7:0] sat_byte;
    input [31:0] v;
    begin
      if (v > 32'h000000ff)
        sat_byte = 8'hff;
      else
        sat_byte = v[7:0];
    end
  endfunction
  // Skipped null bytes never enter the FIFO, so they take no space.
  wire [TX_AW:0] tx_free = TX_DEPTH - tx_cnt;
  // Address decode; both status offsets reach the one status word.
  wire setup = psel_i && !penable_i;
  wire a_block = paddr_i == `BCP_OFF_BLOCK;
  wire a_nblk = paddr_i == `BCP_OFF_NONBLOCK;
  wire a_stat = paddr_i == `BCP_OFF_STATUS_A || paddr_i == `BCP_OFF_STATUS_B;
  // Access phase of a data write or read; pwrite is held through the access.
  wire wr_phase = state == ST_PUSH && pwrite_i;
  wire rd_phase = state == ST_PUSH && !pwrite_i;
  // Bit 31 shows the port enable, bits 14:0 the transmit side.
  wire [31:0] status_word = {port_enabled, 16'h0000,
    (TX_PRESENT != 0) ? {tx_link_fault, tx_overflow_flag, remote_reboot_block,
    4'h0, tx_free_space} : 15'h0000};

  // Transmit queue; its head register feeds the link output stage.
  bcp_fifo #(.AW(TX_AW)) u_tx (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .push_i(tx_push), .wdata_i(tx_byte), .pop_i(tx_pop), .rdata_o(tx_head),
    .count_o(tx_cnt));
  // Receive queue; a fault byte joins it when a dropped byte is reported, unless a receive byte is pushed in that cycle.
  bcp_fifo #(.AW(RX_AW)) u_rx (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .push_i(rx_push_i || rx_link_fault_push_o), .wdata_i(rx_push_i ? rx_data_i :
    `BCP_LINK_FAULT_FLAG_BYTE_BYTE), .pop_i(rx_pop), .rdata_o(rx_head), .count_o(rx_cnt));

  // Stall test: the whole remaining word must fit before any of it is queued,
  // otherwise a later lane could find the FIFO full and the word would split.
  always @* begin
    wr_stall = blocking && lane == 3'h0 &&
      tx_free < {{(TX_AW-2){1'b0}}, needed(wbuf)};
  end
  // Byte pusher: one byte a cycle from the latched write word.
  // It only runs in a write access, so a word left behind by a write that a
  // link fault cut short can never be queued again by a later read.
  always @* begin
    tx_push = 1'b0;
    tx_byte = wbuf[7:0];
    drop_ev = 1'b0;
    ovf_ev = 1'b0;
    if (wr_phase && !wr_stall && !tx_link_fault && lane < TX_BYTE_WIDTH &&
        wbuf[7:0] != `BCP_NULL_BYTE) begin
      if (!link_up_i)
        drop_ev = 1'b1;
      else if (wbuf[7:0] == `BCP_REBOOT_BYTE && remote_reboot_block)
        tx_push = 1'b0;
      else if (tx_free != 0)
        tx_push = 1'b1;
      else
        ovf_ev = !blocking;
    end
  end
  // Drain the transmit FIFO towards the link.
  // A pop is held off while the previous head is still loading.
  always @* begin
    tx_pop = tx_cnt != {(TX_AW+1){1'b0}} && !tx_load && (!tx_valid_o || tx_ready_i);
  end
  // Only lanes 0 to 3 of a read pop, so no byte is lost past the fourth.
  always @* begin
    rx_pop = rd_phase && lane != 3'h4 && rx_cnt != {(RX_AW+1){1'b0}} &&
      port_enabled;
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pen_m <= 1'b0;
      port_enabled <= 1'b0;
      rrd_m <= 1'b0;
      remote_reboot_block <= 1'b0;
      tx_link_fault <= 1'b0;
      tx_overflow_flag <= 1'b0;
      state <= ST_IDLE;
      wbuf <= 32'h00000000;
      lane <= 3'h0;
      blocking <= 1'b0;
      rd_pend <= 2'h0;
      rd_acc <= 32'h00000000;
      tx_free_space <= `BCP_TXS_RESET;
      tx_load <= 1'b0;
      prdata_o <= 32'h00000000;
      pready_o <= 1'b1;
      pslverr_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      rx_link_fault_push_o <= 1'b0;
    end else if (ce_i) begin
      // Two-flop synchronisers; only the second stage is read elsewhere.
      pen_m <= port_enable_input_i;
      port_enabled <= pen_m;
      rrd_m <= reboot_block_input_i;
      remote_reboot_block <= rrd_m;
      tx_free_space <= sat_byte({{(31-TX_AW){1'b0}}, tx_free});
      rx_link_fault_push_o <= 1'b0;
      pslverr_o <= 1'b0;
      // The FIFO head register holds the popped byte one cycle after the pop,
      // so the link register loads from it then; a byte taken meanwhile
      // empties the link register for that cycle.
      tx_load <= tx_pop;
      if (tx_load) begin
        tx_valid_o <= 1'b1;
        tx_data_o <= tx_head;
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      // Sticky flags; hardware set wins over software clear.
      if (setup && pwrite_i && a_stat) begin
        if (pwdata_i[`BCP_BIT_TX_LINK_FAULT])
          tx_link_fault <= 1'b0;
        if (pwdata_i[`BCP_BIT_TX_OVERFLOW_FLAG])
          tx_overflow_flag <= 1'b0;
      end
      if (drop_ev && TX_PRESENT != 0) begin
        tx_link_fault <= 1'b1;
        rx_link_fault_push_o <= 1'b1;
      end
      if (ovf_ev && TX_PRESENT != 0)
        tx_overflow_flag <= 1'b1;
      // Access sequencer: idle, byte stepping, then one cycle to raise ready.
      case (state)
        ST_IDLE: begin
          pready_o <= 1'b1;
          if (setup) begin
            pready_o <= 1'b0;
            state <= ST_DONE;
            prdata_o <= 32'h00000000;
            if (pwrite_i && (a_block || a_nblk)) begin
              // Writes dropped when absent, disabled or flagged.
              if (TX_PRESENT != 0 && port_enabled && !tx_link_fault &&
                  !tx_overflow_flag) begin
                wbuf <= pwdata_i;
                lane <= 3'h0;
                blocking <= a_block;
                state <= ST_PUSH;
              end
            end else if (!pwrite_i && (a_block || a_nblk)) begin
              rd_pend <= 2'h3;
              rd_acc <= {4{`BCP_NULL_BYTE}};
              lane <= 3'h0;
              state <= (RX_PRESENT != 0) ? ST_PUSH : ST_DONE;
              if (RX_PRESENT == 0)
                prdata_o <= 32'h00000000;
            end else if (!pwrite_i && a_stat) begin
              prdata_o <= status_word;
            end
          end
        end
        ST_PUSH: begin
          if (pwrite_i) begin
            // Blocking write waits for room for all remaining needed bytes.
            if (tx_link_fault) begin
              state <= ST_DONE;
            end else if (wr_stall) begin
              state <= ST_PUSH;
            end else begin
              wbuf <= {8'h00, wbuf[31:8]};
              lane <= lane + 3'h1;
              if (lane == 3'h3)
                state <= ST_DONE;
            end
          end else begin
            // Read gathers bytes; lane steps each cycle so reads never stall.
            if (rd_pend == 2'h2 && lane != 3'h0)
              rd_acc[8*(lane-3'h1) +: 8] <= rx_head;
            if (lane == 3'h4) begin
              state <= ST_DONE;
              // The fourth byte is still in the head register at this edge.
              if (rd_pend == 2'h2)
                prdata_o <= {rx_head, rd_acc[23:0]};
              else
                prdata_o <= rd_acc;
            end else begin
              rd_pend <= rx_pop ? 2'h2 : 2'h1;
              lane <= lane + 3'h1;
            end
          end
        end
        ST_DONE: begin
          // Ready rises here and stays high until the next setup phase.
          pready_o <= 1'b1;
          rd_pend <= 2'h0;
          if (psel_i && penable_i && !pready_o)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** sim/bcp_props.sv ***
// Purpose: Port checks for the com port core.
// Assumes: ce_i is held high by the bench.
// Notes: Wait bounds follow the core's hand-over timing.
`timescale 1ns/10ps
module bcp_props (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire tx_valid_o,
  input wire [7:0] tx_data_o,
  input wire tx_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // A setup phase is the moment the core takes a request.
  wire setup = psel_i && !penable_i && ce_i;
  ok_resp_a: assert property (pready_o |-> !pslverr_o) else $error("error response");
  stall_start_a: assert property (setup |=> !pready_o) else $error("no wait state");
  status_fast_a: assert property (setup && paddr_i == 12'h02c |-> ##[2:3] pready_o)
    else $error("status access slow");
  read_bound_a: assert property (setup && !pwrite_i |-> ##[1:12] pready_o)
    else $error("read stalled");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("link byte changed while held");
  no_null_a: assert property (tx_valid_o |-> tx_data_o != 8'h00) else $error("null sent");
  rd_stable_a: assert property (!psel_i |=> $stable(prdata_o)) else $error("read data moved");
  rst_idle_a: assert property (disable iff (1'b0) sys_rst_i |=> pready_o && !tx_valid_o)
    else $error("reset state wrong");
endmodule
bind bcp_core bcp_props u_bcp_props (.clk_i, .sys_rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .tx_valid_o, .tx_data_o, .tx_ready_i);

// *** sim/bcp_remote_rx.sv ***
// Purpose: Remote receive engine that takes bytes off the transmit link.
// Assumes: A byte passes at a rising edge with valid and ready high.
// Notes: stop_i holds it back; slow_i lets it take one byte in four cycles.
`timescale 1ns/10ps
module bcp_remote_rx (
  input wire clk_i,
  input wire stop_i,
  input wire slow_i,
  input wire valid_i,
  input wire [7:0] data_i,
  output logic ready_o = 1'b0
);
  logic [1:0] cnt = 2'h0;
  logic [7:0] got_q[$];
  // Bytes are logged in arrival order; ready moves only after an edge.
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    if (valid_i && ready_o) got_q.push_back(data_i);
    ready_o <= !stop_i && (!slow_i || cnt == 2'h3);
  end
endmodule

// *** sim/bcp_core_tb.sv ***
// Purpose: Self-checking bench for the com port core.
// Assumes: Null byte 0x00, reboot byte 0xab, four byte transmit width.
// Notes: Writes carry no null padding beyond the width, which is four.
`timescale 1ns/10ps
`include "bcp_defs.vh"
module bcp_core_tb;
  logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, rx_push_i = 0;
  logic port_enable_input_i = 1, reboot_block_input_i = 0, link_up_i = 1, stop = 0, slow = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd, lfsr = 32'hb4e9c47c;
  logic [7:0] rx_data_i = 0, exp_q[$];
  wire [31:0] prdata_o;
  wire [7:0] tx_data_o;
  wire pready_o, pslverr_o, tx_valid_o, tx_ready_i, rx_link_fault_push_o;
  int fails = 0, checked = 0, n0;
  bcp_core u_bcp_core (.clk_i, .sys_rst_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .port_enable_input_i,
    .reboot_block_input_i, .link_up_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .rx_push_i,
    .rx_data_i, .rx_link_fault_push_o);
  bcp_remote_rx u_bcp_remote_rx (.clk_i, .stop_i(stop), .slow_i(slow), .valid_i(tx_valid_o),
    .data_i(tx_data_o), .ready_o(tx_ready_i));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One APB access; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i) {psel_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, w, a, d};
    @(negedge clk_i) penable_i = 1;
    do @(posedge clk_i); while (!pready_o);
    rd = prdata_o;
    @(negedge clk_i) {psel_i, penable_i} = 2'b00;
  endtask
  // Model of the transmit path: lanes low first, null and blocked reboot bytes dropped.
  task automatic wr_blk(input logic [31:0] d);
    apb(1, `BCP_OFF_BLOCK, d);
    for (int i = 0; i < 4; i++)
      if (d[8*i+:8] != 8'h00 && !(reboot_block_input_i && d[8*i+:8] == 8'hab))
        exp_q.push_back(d[8*i+:8]);
  endtask
  task automatic drain;
    for (int n = 0; n < 800 && u_bcp_remote_rx.got_q.size() < exp_q.size(); n++)
      @(negedge clk_i);
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Free-running clock at 250 MHz.
  initial forever #2 clk_i = ~clk_i;
  // A hang is cut short well past the expected run length.
  initial begin
    #200000;
    fails++;
    complete_run;
  end
  // Main sequence of tests.
  initial begin
    repeat (10) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (4) @(negedge clk_i);
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[14:8], 7'h00);
    reboot_block_input_i = 1;
    repeat (3) @(negedge clk_i);
    apb(0, `BCP_OFF_STATUS_B, 0);
    chk(rd[12], 1'b1);
    wr_blk(32'h00ab_5aab);
    reboot_block_input_i = 0;
    repeat (4) @(negedge clk_i);
    wr_blk(32'h0000_00ab);
    slow = 1;
    repeat (12) begin
      lfsr = nxt(lfsr);
      wr_blk(lfsr);
    end
    drain;
    chk(u_bcp_remote_rx.got_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(u_bcp_remote_rx.got_q[i], exp_q[i]);
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[7:0] != 8'h00, 1'b1);
    $display("transmit test done");
    @(negedge clk_i) {rx_push_i, rx_data_i} = 9'h15a;
    @(negedge clk_i) rx_data_i = 8'hc3;
    @(negedge clk_i) rx_push_i = 0;
    apb(0, `BCP_OFF_BLOCK, 0);
    chk(rd, 32'h0000_c35a);
    $display("receive test done");
    link_up_i = 0;
    apb(1, `BCP_OFF_BLOCK, 32'h1122_3344);
    link_up_i = 1;
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[14], 1'b1);
    n0 = u_bcp_remote_rx.got_q.size();
    apb(1, `BCP_OFF_BLOCK, 32'h0000_0055);
    repeat (30) @(negedge clk_i);
    chk(u_bcp_remote_rx.got_q.size(), n0);
    apb(1, `BCP_OFF_STATUS_A, 32'h0000_4000);
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[14], 1'b0);
    $display("link fault test done");
    stop = 1;
    repeat (6) apb(1, `BCP_OFF_NONBLOCK, 32'h0102_0304);
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[13], 1'b1);
    stop = 0;
    repeat (200) @(negedge clk_i);
    n0 = u_bcp_remote_rx.got_q.size();
    apb(1, `BCP_OFF_BLOCK, 32'h0000_0077);
    repeat (30) @(negedge clk_i);
    chk(u_bcp_remote_rx.got_q.size(), n0);
    apb(1, `BCP_OFF_STATUS_A, 32'h0000_2000);
    apb(0, `BCP_OFF_STATUS_A, 0);
    chk(rd[13], 1'b0);
    $display("overflow test done");
    complete_run;
  end
endmodule
